// *** src/dtms_channel.sv ***
// Function
// [R1] mode field: 000 single, 001 block, 01x burst, 100/101/11x repeated forms.
// [R2] each channel keeps its own mode; any step setting works with any mode.
// [R3] separate source and destination byte/word width selects, all four combinations.
// [R4] single mode moves one unit per accepted trigger.
// [R5] a programmed count of zero performs no transfer.
// [R6] working pointer copies step after each transfer per step selection.
// [R7] count decrements per transfer; at zero reloads and sets done flag.
// [R8] mode 000 clears enable at count zero; software re-enables.
// [R9] repeated single keeps enable set, one transfer per trigger.
// [R10] block mode moves whole block per trigger, then clears enable.
// [R11] triggers during a running block or burst-block are ignored.
// [R12] cpu halted during block, two clocks per transfer, then resumes.
// [R13] repeated block keeps enable; next trigger starts a new block.
// [R14] burst modes release cpu two clocks after every four transfers.
// [R15] non-repeated burst ends with cpu full speed and enable cleared.
// [R16] repeated burst restarts at once without trigger, cpu stays interleaved.
// [R17] repeated burst stops on enable clear or nmi with abort enabled.
// [R18] word-to-byte writes low byte; byte-to-word clears upper byte.
// [R19] step selection: increment, decrement or unchanged.
// [R20] edge trigger select: rising edge starts transfer or block.
// [R21] working copies load on enable rising and at each reload.
`timescale 1ns/100ps
`default_nettype none
`include "dtms_defines.svh"
module dtms_channel #(
    parameter int AW = 16
)
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        trig_in,
    input  wire logic        nmi_in,
    output logic             cpu_halt,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [AW-1:0]    mem_addr,
    output logic             mem_byte,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata
);
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p, input logic [1:0] s,
                                                input logic byte_w);
        logic [AW-1:0] d;
        d = byte_w ? AW'(1) : AW'(2);
        case (s)
            `DTMS_STEP_INC: step_ptr = p + d; // [R19]
            `DTMS_STEP_DEC: step_ptr = p - d; // [R19]
            default:        step_ptr = p;
        endcase
    endfunction

    logic [31:0]     ctl_reg;
    logic [AW-1:0]   src_reg, dst_reg, wsrc_reg, wdst_reg;
    logic [15:0]     cnt_reg, wcnt_reg, data_reg;
    logic [1:0]      grp_reg, gap_reg;
    logic            ack_reg, en_prev_reg, nmi_prev_reg, busy_reg;
    dtms_pkg::dtms_state_t state_reg;

    wire [2:0] mode    = ctl_reg[`DTMS_CTL_MODE_LSB +: 3]; // [R2]
    wire       en      = ctl_reg[`DTMS_CTL_EN_BIT];
    wire [1:0] sstep   = ctl_reg[`DTMS_CTL_SSTEP_LSB +: 2];
    wire [1:0] dstep   = ctl_reg[`DTMS_CTL_DSTEP_LSB +: 2];
    wire       sbyte   = ctl_reg[`DTMS_CTL_SW_BIT];
    wire       dbyte   = ctl_reg[`DTMS_CTL_DW_BIT];
    wire       repeat_m = mode[2];
    // [R1] decode of the mode field
    wire dtms_pkg::dtms_kind_t kind = (mode[1:0] == 2'b00) ? dtms_pkg::DTMS_SINGLE :
                                      (mode[1:0] == 2'b01) ? dtms_pkg::DTMS_BLOCK :
                                                             dtms_pkg::DTMS_BURST;
    wire is_single = (kind == dtms_pkg::DTMS_SINGLE);
    wire is_burst  = (kind == dtms_pkg::DTMS_BURST);

    wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
    // a write lands on the edge the master sees ack, never while the request may still move
    wire bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    wire wr_ctl   = bus_wr & (wb_adr_i == `DTMS_OFS_CTL);
    wire wr_src   = bus_wr & (wb_adr_i == `DTMS_OFS_SRC);
    wire wr_dst   = bus_wr & (wb_adr_i == `DTMS_OFS_DST);
    wire wr_cnt   = bus_wr & (wb_adr_i == `DTMS_OFS_CNT);

    logic trig_req;
    dtms_trig_det u_trig (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n_reg),
        .trig_in   (trig_in),
        .level_sel (ctl_reg[`DTMS_CTL_LVL_BIT]),
        .trig_req  (trig_req)
    );

    wire en_rise   = en & ~en_prev_reg;
    wire nmi_abort = nmi_in & ~nmi_prev_reg & ctl_reg[`DTMS_CTL_NMI_BIT];
    // idle channels accept a trigger; a running block ignores it
    wire start     = (state_reg == dtms_pkg::DTMS_IDLE) & en & ~en_rise &
                     (wcnt_reg != 16'h0000) & trig_req; // [R5] [R11]
    wire wr_done   = (state_reg == dtms_pkg::DTMS_WR);
    wire last_xfer = wr_done & (cnt_reg == 16'h0001);
    wire end_unit  = wr_done & (is_single | last_xfer);
    wire clr_en    = last_xfer & ~repeat_m; // [R8] [R9] [R10] [R13] [R15]
    wire need_gap  = wr_done & is_burst & ~last_xfer & (grp_reg == 2'(`DTMS_BURST_GROUP - 1));
    // repeated burst chains into the next block without a trigger
    wire chain     = last_xfer & is_burst & repeat_m & en & ~nmi_abort; // [R16]

    // [R18] width conversion: byte source zero-extends, byte dest keeps low byte
    wire [15:0] wdata = sbyte ? {8'h00, data_reg[7:0]} : data_reg;

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            state_reg <= dtms_pkg::DTMS_IDLE;
        else
            case (state_reg)
                dtms_pkg::DTMS_IDLE: if (start) state_reg <= dtms_pkg::DTMS_RD;
                dtms_pkg::DTMS_RD:   state_reg <= dtms_pkg::DTMS_WR; // [R12]
                dtms_pkg::DTMS_WR:
                    if (need_gap)
                        state_reg <= dtms_pkg::DTMS_GAP; // [R14]
                    else if (end_unit & ~chain)
                        state_reg <= dtms_pkg::DTMS_IDLE;
                    else if (~en | nmi_abort)
                        state_reg <= dtms_pkg::DTMS_IDLE; // [R17]
                    else if (chain)
                        state_reg <= dtms_pkg::DTMS_GAP;
                    else
                        state_reg <= dtms_pkg::DTMS_RD;
                dtms_pkg::DTMS_GAP:
                    if (~en | nmi_abort)
                        state_reg <= dtms_pkg::DTMS_IDLE; // [R17]
                    else if (gap_reg == 2'(`DTMS_CPU_GAP - 1))
                        state_reg <= dtms_pkg::DTMS_RD;
                default: state_reg <= dtms_pkg::DTMS_IDLE;
            endcase
    end

    // busy flags an active unit one cycle late; status only, so the lag does no harm
    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            busy_reg     <= 1'b0;
            grp_reg      <= 2'h0;
            gap_reg      <= 2'h0;
            en_prev_reg  <= 1'b0;
            nmi_prev_reg <= 1'b0;
            data_reg     <= 16'h0000;
        end
        else
        begin
            busy_reg     <= (state_reg != dtms_pkg::DTMS_IDLE);
            en_prev_reg  <= en;
            nmi_prev_reg <= nmi_in;
            if (state_reg == dtms_pkg::DTMS_RD)
                data_reg <= mem_rdata;
            if (start | chain)
                grp_reg <= 2'h0;
            else if (wr_done)
                grp_reg <= grp_reg + 2'h1;
            gap_reg <= (state_reg == dtms_pkg::DTMS_GAP) ? gap_reg + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctl_reg <= `DTMS_CTL_RESET;
            src_reg <= '0;
            dst_reg <= '0;
        end
        else
        begin
            if (wr_ctl & wb_sel_i[0])
                ctl_reg[7:0] <= wb_dat_i[7:0];
            if (wr_ctl & wb_sel_i[1])
                ctl_reg[11:8] <= wb_dat_i[11:8];
            if (wr_ctl & wb_sel_i[1] & wb_dat_i[`DTMS_CTL_DONE_BIT])
                ctl_reg[`DTMS_CTL_DONE_BIT] <= 1'b0;
            if (clr_en | (nmi_abort & (state_reg != dtms_pkg::DTMS_IDLE)))
                ctl_reg[`DTMS_CTL_EN_BIT] <= 1'b0; // [R8] [R10] [R15] [R17]
            if (last_xfer)
                ctl_reg[`DTMS_CTL_DONE_BIT] <= 1'b1; // [R7] set wins over clear
            if (wr_src)
                src_reg <= wb_dat_i[AW-1:0];
            if (wr_dst)
                dst_reg <= wb_dat_i[AW-1:0];
        end
    end

    // count register is the visible remaining count; wcnt is the reload copy
    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            cnt_reg  <= 16'h0000;
            wcnt_reg <= 16'h0000;
            wsrc_reg <= '0;
            wdst_reg <= '0;
        end
        else if (en_rise)
        begin
            wcnt_reg <= cnt_reg; // [R21]
            wsrc_reg <= src_reg; // [R6] [R21]
            wdst_reg <= dst_reg;
        end
        else if (wr_cnt)
            cnt_reg <= wb_dat_i[15:0];
        else if (wr_done)
        begin
            cnt_reg  <= last_xfer ? wcnt_reg : cnt_reg - 16'h0001; // [R7]
            wsrc_reg <= last_xfer ? src_reg : step_ptr(wsrc_reg, sstep, sbyte); // [R6] [R21]
            wdst_reg <= last_xfer ? dst_reg : step_ptr(wdst_reg, dstep, dbyte); // [R6] [R3]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ack_reg <= 1'b0;
        else
            ack_reg <= bus_req;
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req & ~wb_we_i)
            case (wb_adr_i)
                `DTMS_OFS_CTL:  wb_dat_o <= {19'h0, ctl_reg[12:0]};
                `DTMS_OFS_SRC:  wb_dat_o <= 32'(src_reg);
                `DTMS_OFS_DST:  wb_dat_o <= 32'(dst_reg);
                `DTMS_OFS_CNT:  wb_dat_o <= {16'h0, cnt_reg};
                `DTMS_OFS_STAT: wb_dat_o <= {30'h0, busy_reg, cpu_halt};
                `DTMS_OFS_WSRC: wb_dat_o <= 32'(wsrc_reg);
                `DTMS_OFS_WDST: wb_dat_o <= 32'(wdst_reg);
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
    end

    assign wb_ack_o = ack_reg;
    // cpu halted in transfer cycles, free during idle and burst gaps
    assign cpu_halt = (state_reg == dtms_pkg::DTMS_RD) | wr_done; // [R12] [R14]
    assign mem_rd   = (state_reg == dtms_pkg::DTMS_RD);
    assign mem_wr   = wr_done; // [R4]
    assign mem_addr = mem_rd ? wsrc_reg : wdst_reg;
    assign mem_byte = mem_rd ? sbyte : dbyte; // [R3]
    assign mem_wdata = wdata; // [R18]

    a_two_cycle_xfer: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R12]
        mem_rd |=> mem_wr) else $error("write does not follow read");
    a_zero_no_xfer: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R5]
        (state_reg == dtms_pkg::DTMS_IDLE && wcnt_reg == 16'h0000) |=> !mem_rd)
        else $error("transfer with zero count");
    a_single_clr_en: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R8]
        (last_xfer && mode == 3'b000) |=> !en) else $error("enable not cleared");
    a_rep_keep_en: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R9] [R13]
        (last_xfer && repeat_m && en && !wr_ctl && !nmi_abort) |=> en)
        else $error("repeat mode lost enable");
    a_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R7]
        last_xfer |=> ctl_reg[`DTMS_CTL_DONE_BIT]) else $error("done flag missed");
    sequence s_group4;
        wr_done && is_burst && !last_xfer && grp_reg == 2'h3;
    endsequence
    a_burst_gap: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R14]
        s_group4 |=> !cpu_halt [*2]) else $error("cpu gap missing");
    // a chain cut by an enable clear or an nmi abort legally never reaches the next read
    a_rep_burst_chain: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R16]
        chain |-> ##[1:3] (mem_rd || !en)) else $error("repeated burst did not restart");
    a_reload_count: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R7]
        (last_xfer && !en_rise) |=> cnt_reg == $past(wcnt_reg)) else $error("no reload");
    a_single_one: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R4]
        (wr_done && is_single) |=> state_reg == dtms_pkg::DTMS_IDLE)
        else $error("single moved more than one");
    a_block_no_gap: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R12]
        (wr_done && kind == dtms_pkg::DTMS_BLOCK && !last_xfer && en && !nmi_abort) |=> mem_rd)
        else $error("block released the cpu early");
    a_burst_clr_en: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R15]
        (last_xfer && is_burst && !repeat_m) |=> !en)
        else $error("burst left enable set");
    a_unit_idle: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // [R10] [R11]
        (last_xfer && !chain) |=> state_reg == dtms_pkg::DTMS_IDLE)
        else $error("unit did not end after its last transfer");
endmodule
`default_nettype wire

// *** src/dtms_defines.svh ***
`ifndef DTMS_DEFINES_SVH
`define DTMS_DEFINES_SVH

// register byte offsets
`define DTMS_OFS_CTL      8'h00
`define DTMS_OFS_SRC      8'h04
`define DTMS_OFS_DST      8'h08
`define DTMS_OFS_CNT      8'h0C
`define DTMS_OFS_STAT     8'h10
`define DTMS_OFS_WSRC     8'h14
`define DTMS_OFS_WDST     8'h18

// channel_control fields
`define DTMS_CTL_EN_BIT    0
`define DTMS_CTL_MODE_LSB  1
`define DTMS_CTL_SSTEP_LSB 4
`define DTMS_CTL_DSTEP_LSB 6
`define DTMS_CTL_SW_BIT    8
`define DTMS_CTL_DW_BIT    9
`define DTMS_CTL_LVL_BIT   10
`define DTMS_CTL_NMI_BIT   11
`define DTMS_CTL_DONE_BIT  12
`define DTMS_CTL_RESET     32'h0000_0000

// step selection encodings
`define DTMS_STEP_DEC      2'h2
`define DTMS_STEP_INC      2'h3

// timing
`define DTMS_XFER_CYCLES   2
`define DTMS_BURST_GROUP   4
`define DTMS_CPU_GAP       2

`endif

// *** src/dtms_pkg.sv ***
package dtms_pkg;
    typedef enum logic [1:0] {DTMS_SINGLE, DTMS_BLOCK, DTMS_BURST} dtms_kind_t;
    typedef enum {DTMS_IDLE, DTMS_RD, DTMS_WR, DTMS_GAP} dtms_state_t;
endpackage

// *** src/dtms_trig_det.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtms_trig_det
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic trig_in,
    input  wire logic level_sel,
    output logic      trig_req
);
    logic trig_prev_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            trig_prev_reg <= 1'b0;
        else
            trig_prev_reg <= trig_in;
    end

    // level mode asks while high; edge mode only on a rising edge
    assign trig_req = level_sel ? trig_in : (trig_in & ~trig_prev_reg); // [R20]
endmodule
`default_nettype wire

// *** verification/dtms_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtms_mem_model
(
    input  wire logic        sys_clk,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_byte,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    output int               wr_count
);
    logic [7:0]  mem [0:255];
    logic [15:0] last_q;
    wire  [7:0]  a = mem_addr[7:0];
    // outside a read the bus shows the inverse of its last value, so a late sample never matches
    assign mem_rdata = mem_rd ? {mem[a + 8'h01], mem[a]} : ~last_q;
    initial
    begin
        wr_count = 0;
        last_q = 16'h0000;
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0];
    end
    always @(posedge sys_clk)
    begin
        last_q <= mem_rdata;
        if (mem_wr)
        begin
            mem[a] <= mem_wdata[7:0];
            if (!mem_byte)
                mem[a + 8'h01] <= mem_wdata[15:8];
            wr_count <= wr_count + 1;
        end
    end
endmodule
`default_nettype wire

// *** verification/test_dma_transfer_mode_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_dma_transfer_mode_sequencer;
    logic        sys_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        trig = 1'b0, nmi = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, c;
    wire  [31:0] dat_o;
    wire         ack, halt, mrd, mwr, mbyte;
    wire  [15:0] maddr, mwd, mrdata;
    int          wrc, w0, failures = 0, tests_run = 0, cycles = 0, halt_n = 0, run = 0, max_run = 0;

    dtms_channel #(.AW(16)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_in(trig), .nmi_in(nmi), .cpu_halt(halt),
        .mem_rd(mrd), .mem_wr(mwr), .mem_addr(maddr), .mem_byte(mbyte), .mem_wdata(mwd),
        .mem_rdata(mrdata));
    dtms_mem_model mdl (.sys_clk(sys_clk), .mem_rd(mrd), .mem_wr(mwr), .mem_addr(maddr),
        .mem_byte(mbyte), .mem_wdata(mwd), .mem_rdata(mrdata), .wr_count(wrc));

    always #25 sys_clk = ~sys_clk;

    task complete_run;
        $display("counts failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // halt cycles and longest unbroken halt run, plus the hang limit
    always @(posedge sys_clk)
    begin
        cycles++;
        if (halt === 1'b1)
            run++;
        else
        begin
            if (run > max_run)
                max_run = run;
            run = 0;
        end
        if (halt === 1'b1)
            halt_n++;
        if (cycles == 30000)
        begin
            failures++;
            complete_run();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge sys_clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task pulse_trig;
        @(posedge sys_clk);
        trig <= 1'b1;
        @(posedge sys_clk);
        trig <= 1'b0;
    endtask

    // waits for six quiet cycles; burst gaps are only two long
    task settle;
        int q;
        q = 0;
        for (int i = 0; i < 300 && q < 6; i++)
        begin
            @(posedge sys_clk);
            q = (halt === 1'b0 && mrd === 1'b0 && mwr === 1'b0) ? q + 1 : 0;
        end
    endtask

    // working copies load after enable rises, so count goes in first
    task cfg(input logic [7:0] s, input logic [7:0] d, input logic [15:0] n, input logic [31:0] k);
        wb(1'b1, 8'h00, 32'h1000);
        wb(1'b1, 8'h04, {24'h0, s});
        wb(1'b1, 8'h08, {24'h0, d});
        wb(1'b1, 8'h0C, {16'h0, n});
        wb(1'b1, 8'h00, k);
        repeat (2) @(posedge sys_clk);
        w0 = wrc;
        halt_n = 0;
        max_run = 0;
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] ss,
        input logic [1:0] ds, input logic sw, input logic dw, input logic na);
        return {19'h0, 1'b0, na, 1'b0, dw, sw, ds, ss, m, 1'b1};
    endfunction

    function automatic logic [15:0] mw(input logic [7:0] a);
        return {mdl.mem[a + 8'h01], mdl.mem[a]};
    endfunction

    initial
    begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk(8'h00, 32'h0);
        wb(1'b1, 8'h1C, 32'hFFFF);
        rchk(8'h1C, 32'h0);
        c = ctl(3'h0, 2'h3, 2'h3, 1'b0, 1'b0, 1'b0);
        cfg(8'h10, 8'h80, 16'h2, c);
        pulse_trig();
        settle();
        check({16'h0, mw(8'h80)}, 32'h1110);
        check(32'(wrc - w0), 32'h1);
        rchk(8'h0C, 32'h1);
        rchk(8'h14, 32'h12);
        rchk(8'h18, 32'h82);
        pulse_trig();
        settle();
        rchk(8'h0C, 32'h2);
        rchk(8'h00, (c & ~32'h1) | 32'h1000);
        pulse_trig();
        settle();
        check(32'(wrc - w0), 32'h2);
        c = ctl(3'h1, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0);
        cfg(8'h20, 8'h90, 16'h3, c);
        pulse_trig();
        pulse_trig();
        settle();
        check(32'(halt_n), 32'h6);
        check(32'(wrc - w0), 32'h3);
        check({16'h0, mw(8'h90)}, 32'h1D1C);
        rchk(8'h14, 32'h20);
        rchk(8'h00, (c & ~32'h1) | 32'h1000);
        cfg(8'h20, 8'h90, 16'h0, c);
        pulse_trig();
        settle();
        check(32'(wrc - w0), 32'h0);
        c = ctl(3'h4, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0);
        cfg(8'h31, 8'hA0, 16'h3, c);
        pulse_trig();
        settle();
        check({16'h0, mw(8'hA0)}, 32'h0031);
        pulse_trig();
        settle();
        check(32'(wrc - w0), 32'h2);
        rchk(8'h00, c);
        c = ctl(3'h4, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0);
        cfg(8'h40, 8'hB1, 16'h1, c);
        pulse_trig();
        settle();
        check({16'h0, mw(8'hB1)}, 32'hB240);
        rchk(8'h00, c | 32'h1000);
        c = ctl(3'h5, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0);
        cfg(8'h50, 8'hD0, 16'h2, c);
        pulse_trig();
        settle();
        pulse_trig();
        settle();
        check(32'(wrc - w0), 32'h4);
        rchk(8'h00, c | 32'h1000);
        c = ctl(3'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0) | 32'h400;
        cfg(8'h10, 8'hE0, 16'h3, c);
        @(posedge sys_clk);
        trig <= 1'b1;
        repeat (20) @(posedge sys_clk);
        trig <= 1'b0;
        settle();
        check(32'(wrc - w0), 32'h3);
        c = ctl(3'h2, 2'h3, 2'h3, 1'b0, 1'b0, 1'b0);
        cfg(8'h00, 8'hC0, 16'h6, c);
        pulse_trig();
        settle();
        check(32'(max_run), 32'h8);
        check(32'(halt_n), 32'hC);
        rchk(8'h00, (c & ~32'h1) | 32'h1000);
        for (int i = 0; i < 8; i++)
        begin
            cfg(8'h10, 8'hE0, 16'h1, ctl(i[2:0], 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
            pulse_trig();
            settle();
            wb(1'b0, 8'h00, 32'h0);
            check({31'h0, rd[0]}, {31'h0, i[2]});
            if (i < 6)
                check(32'(wrc - w0), 32'h1);
            else
            begin
                check({31'h0, (wrc - w0) > 5}, 32'h1);
                wb(1'b0, 8'h10, 32'h0);
                check({31'h0, rd[1]}, 32'h1);
                @(posedge sys_clk);
                nmi <= 1'b1;
                @(posedge sys_clk);
                nmi <= 1'b0;
                settle();
                wb(1'b0, 8'h00, 32'h0);
                check({31'h0, rd[0]}, 32'h0);
                rchk(8'h10, 32'h0);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
